// file: ihb_cfg.svh
// Constants of the host bus port: widths, address windows and bus timing.
// Included by the package; holds definitions only.
`ifndef IHB_CFG_SVH
`define IHB_CFG_SVH

`define IHB_ADDR_W 19
`define IHB_DATA_W 16
// Memory window: A[18:17] tag, so the block answers a 128K slice of the bus
`define IHB_MEM_TAG_LSB 17
`define IHB_MEM_TAG 2'h1
// I/O window on A[9:0]; A[15:10] must be zero
`define IHB_IO_LO 10'h3B0
`define IHB_IO_HI 10'h3DF
// Bus timing
`define IHB_CLK_PERIOD_NS 100
`define IHB_STROBE_MIN_NS 200
`define IHB_STROBE_MIN_CYC ((`IHB_STROBE_MIN_NS + `IHB_CLK_PERIOD_NS - 1) / `IHB_CLK_PERIOD_NS)
// Idle value of a released data line (pulled up)
`define IHB_DATA_IDLE 16'hFFFF

`endif

// file: ihb_pkg.sv
// Types and shared address decoders of the host bus port.
// Assumes ihb_cfg.svh is on the include path.
`include "ihb_cfg.svh"

package ihb_pkg;

	// Device end states
	typedef enum logic [1:0] {
		D_IDLE = 2'b00,
		D_BUSY = 2'b01,
		D_DONE = 2'b10
	} ihb_dev_state_type;

	// Host end states
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_ALE = 2'b01,
		H_STROBE = 2'b10,
		H_RECOVER = 2'b11
	} ihb_host_state_type;

	// Bus cycle kinds the host end can run
	typedef enum logic [2:0] {
		K_IO_RD = 3'b000,
		K_IO_WR = 3'b001,
		K_MEM_RD = 3'b010,
		K_MEM_WR = 3'b011,
		K_REFRESH = 3'b100,
		K_DMA_IO = 3'b101
	} ihb_kind_type;

	// Memory address falls in the block's window
	function automatic logic ihb_mem_hit(input logic [`IHB_ADDR_W-1:0] a);
		ihb_mem_hit = (a[`IHB_ADDR_W-1:`IHB_MEM_TAG_LSB] == `IHB_MEM_TAG);
	endfunction : ihb_mem_hit

	// I/O address falls in the register window
	function automatic logic ihb_io_hit(input logic [`IHB_ADDR_W-1:0] a);
		ihb_io_hit = (a[15:10] == 6'h00) && (a[9:0] >= `IHB_IO_LO) && (a[9:0] <= `IHB_IO_HI);
	endfunction : ihb_io_hit

endpackage : ihb_pkg

// file: ihb_if.sv
// Host bus wires between the system end and the controller end.
// Resolves shared and open-drain lines from the output enables.
`timescale 1ns/1ps

`include "ihb_cfg.svh"

interface ihb_if;
	logic [18:0] addr;
	logic cs;
	logic bale;
	logic aen;
	logic sys_reset;
	logic sbhe_n;
	logic iord_n;
	logic iowr_n;
	logic memr_n;
	logic memw_n;
	logic ref_n;
	logic [15:0] host_data_o;
	logic host_data_oe;
	logic [15:0] dev_data_o;
	logic dev_data_oe;
	logic [15:0] data;
	logic upper_byte_buffer_enable_n;
	logic dir;
	logic memcs16_n_o;
	logic memcs16_n_oe;
	logic memcs16_n;
	logic iochrdy_o;
	logic iochrdy_oe;
	logic iochrdy;
	logic vertical_retrace_irq_o;
	logic vertical_retrace_irq_oe;
	logic vertical_retrace_irq;

	// Released lines float to their pulled level
	assign data = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : `IHB_DATA_IDLE);
	assign memcs16_n = memcs16_n_oe ? memcs16_n_o : 1'b1;
	assign iochrdy = iochrdy_oe ? iochrdy_o : 1'b1;
	assign vertical_retrace_irq = vertical_retrace_irq_oe ? vertical_retrace_irq_o : 1'b0;

	modport dev (
		input addr, cs, bale, aen, sys_reset, sbhe_n, iord_n, iowr_n, memr_n, memw_n, ref_n, data,
		output dev_data_o, dev_data_oe, upper_byte_buffer_enable_n, dir,
		output memcs16_n_o, memcs16_n_oe, iochrdy_o, iochrdy_oe,
		output vertical_retrace_irq_o, vertical_retrace_irq_oe
	);

	modport host (
		output addr, cs, bale, aen, sys_reset, sbhe_n, iord_n, iowr_n, memr_n, memw_n, ref_n,
		output host_data_o, host_data_oe,
		input data, upper_byte_buffer_enable_n, dir, memcs16_n, iochrdy, vertical_retrace_irq
	);
endinterface : ihb_if

// file: ihb_host.sv
// System end of the host bus: runs one I/O, memory, refresh or DMA cycle per command.
// Assumes bus inputs are synchronous to MCLK and the device end sits on the same ihb_if.
`timescale 1ns/1ps

module ihb_host
	import ihb_pkg::*;
#(
	parameter logic [3:0] STROBE_MIN = 4'(`IHB_STROBE_MIN_CYC)
) (
	input wire logic MCLK,
	input wire logic RST_N,
	ihb_if.host BUS,
	input wire logic CMD_VALID,
	input wire ihb_kind_type CMD_KIND,
	input wire logic [18:0] CMD_ADDR,
	input wire logic [15:0] CMD_WDATA,
	input wire logic CMD_WIDE,
	input wire logic RESET_REQ,
	output logic CMD_READY,
	output logic DONE,
	output logic [15:0] DONE_RDATA,
	output logic DONE_WIDE,
	output logic IRQ_SEEN
);

	// The device needs one edge to see a strobe before it can pull ready low
	if (STROBE_MIN < 4'h2) begin : g_chk
		$error("STROBE_MIN must be at least 2");
	end

	ihb_host_state_type state_reg;
	ihb_kind_type kind_reg;
	logic [3:0] cnt_reg;
	logic wide_reg;

	// Decode of the command and of the end of the strobe
	wire logic is_mem = (CMD_KIND == K_MEM_RD) || (CMD_KIND == K_MEM_WR);
	wire logic is_wr = (CMD_KIND == K_IO_WR) || (CMD_KIND == K_MEM_WR);
	wire logic take = CMD_VALID && CMD_READY;
	wire logic strobe_end = (cnt_reg >= STROBE_MIN - 4'h1) && BUS.iochrdy;

	// Reset line and interrupt observation
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			BUS.sys_reset <= 1'b1;
			IRQ_SEEN <= 1'b0;
		end else begin
			BUS.sys_reset <= RESET_REQ;
			IRQ_SEEN <= BUS.vertical_retrace_irq;
		end
	end

	// Cycle sequencer: address phase, strobe phase, recovery
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= H_IDLE;
			kind_reg <= K_IO_RD;
			cnt_reg <= 4'h0;
			wide_reg <= 1'b0;
			CMD_READY <= 1'b1;
			DONE <= 1'b0;
			DONE_RDATA <= 16'h0000;
			DONE_WIDE <= 1'b0;
			BUS.addr <= 19'h0_0000;
			BUS.cs <= 1'b0;
			BUS.bale <= 1'b0;
			BUS.aen <= 1'b0;
			BUS.sbhe_n <= 1'b1;
			BUS.iord_n <= 1'b1;
			BUS.iowr_n <= 1'b1;
			BUS.memr_n <= 1'b1;
			BUS.memw_n <= 1'b1;
			BUS.ref_n <= 1'b1;
			BUS.host_data_o <= 16'h0000;
			BUS.host_data_oe <= 1'b0;
		end else begin
			DONE <= 1'b0;
			unique case (state_reg)
				H_IDLE: begin
					if (take) begin
						// R08 address valid
						BUS.bale <= 1'b1;
						BUS.addr <= CMD_ADDR;
						// R01 select memory target; a refresh keeps its decode so only its mark stops it
						BUS.cs <= (is_mem || (CMD_KIND == K_REFRESH)) && ihb_mem_hit(CMD_ADDR);
						// R07 refresh marked from the address phase on
						BUS.ref_n <= !(CMD_KIND == K_REFRESH);
						// R10 DMA marks aen
						BUS.aen <= (CMD_KIND == K_DMA_IO);
						// R14 I/O stays 8-bit
						BUS.sbhe_n <= !(CMD_WIDE && is_mem);
						BUS.host_data_o <= CMD_WDATA;
						BUS.host_data_oe <= is_wr;
						kind_reg <= CMD_KIND;
						CMD_READY <= 1'b0;
						state_reg <= H_ALE;
					end
				end
				H_ALE: begin
					BUS.bale <= 1'b0;
					// R05 I/O strobes
					BUS.iord_n <= !((kind_reg == K_IO_RD) || (kind_reg == K_DMA_IO));
					BUS.iowr_n <= !(kind_reg == K_IO_WR);
					// R06 memory strobes
					BUS.memr_n <= !((kind_reg == K_MEM_RD) || (kind_reg == K_REFRESH));
					BUS.memw_n <= !(kind_reg == K_MEM_WR);
					cnt_reg <= 4'h0;
					wide_reg <= 1'b0;
					state_reg <= H_STROBE;
				end
				H_STROBE: begin
					if (cnt_reg != 4'hF) begin
						cnt_reg <= cnt_reg + 4'h1;
					end
					// Acknowledge may come late in the cycle, so it is caught any time
					if (!BUS.memcs16_n) begin
						wide_reg <= 1'b1;
					end
					// R12 wait on ready
					if (strobe_end) begin
						BUS.iord_n <= 1'b1;
						BUS.iowr_n <= 1'b1;
						BUS.memr_n <= 1'b1;
						BUS.memw_n <= 1'b1;
						BUS.host_data_oe <= 1'b0;
						DONE_RDATA <= BUS.data;
						DONE_WIDE <= wide_reg || !BUS.memcs16_n;
						DONE <= 1'b1;
						state_reg <= H_RECOVER;
					end
				end
				H_RECOVER: begin
					BUS.cs <= 1'b0;
					BUS.aen <= 1'b0;
					BUS.ref_n <= 1'b1;
					BUS.sbhe_n <= 1'b1;
					CMD_READY <= 1'b1;
					state_reg <= H_IDLE;
				end
			endcase
		end
	end

endmodule : ihb_host

// file: ihb_dev.sv
// Controller end of the host bus: decodes I/O and memory cycles, holds the bus
// with ready until the core answers, and drives the retrace interrupt line.
// Assumes bus inputs are synchronous to MCLK; the core answers each REQ with one ACK.
//
// Functional notes
// R01 - Memory cycles ours only while select high
// R02 - Upper-byte buffer enable low for wide transfers
// R03 - Buffer direction low during host reads
// R04 - Byte-high enable sampled only in 16-bit mode
// R05 - I/O strobes mark I/O read and write
// R06 - Memory strobes mark memory read and write
// R07 - Refresh cycles make memory accesses ignored
// R08 - Address latch enable high means address valid
// R09 - System reset returns state to reset
// R10 - Address enable high ignores I/O strobes
// R11 - Wide acknowledge only in 16-bit mode, in range
// R12 - Ready held low until transfer completes
// R13 - Interrupt raised at vertical retrace start
// R14 - I/O always 8-bit, memory 8 or 16
// R15 - Shared outputs released when not driven
`timescale 1ns/1ps

module ihb_dev
	import ihb_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST_N,
	ihb_if.dev BUS,
	input wire logic MODE16,
	input wire logic IRQ_EN,
	input wire logic VRETRACE,
	input wire logic IRQ_CLR,
	input wire logic ACK,
	input wire logic [15:0] ACK_RDATA,
	output logic REQ,
	output logic REQ_IS_MEM,
	output logic REQ_WRITE,
	output logic REQ_WIDE,
	output logic [18:0] REQ_ADDR,
	output logic [15:0] REQ_WDATA,
	output logic IRQ_PENDING
);

	// Sequencer state, latched address and per-cycle flags
	ihb_dev_state_type state_reg;
	logic [18:0] addr_lat_reg;
	logic is_read_reg;
	logic vr_prev_reg;

	// R08 address valid window
	wire logic [18:0] eff_addr = BUS.bale ? BUS.addr : addr_lat_reg;

	// R01 select qualifies memory
	// R07 refresh masks memory
	wire logic mem_ok = ihb_mem_hit(eff_addr) && BUS.cs && BUS.ref_n;
	// R06 memory strobes
	wire logic mem_rd = !BUS.memr_n && mem_ok;
	wire logic mem_wr = !BUS.memw_n && mem_ok;
	// R10 DMA blocks I/O
	wire logic io_ok = !BUS.aen && ihb_io_hit(BUS.addr);
	// R05 I/O strobes
	wire logic io_rd = !BUS.iord_n && io_ok;
	wire logic io_wr = !BUS.iowr_n && io_ok;

	// Only looked at in IDLE, so strobes seen during a busy cycle are dropped
	wire logic start = mem_rd || mem_wr || io_rd || io_wr;
	wire logic is_mem = mem_rd || mem_wr;
	wire logic is_read = mem_rd || io_rd;
	// R04 byte-high only in 16-bit mode
	// R14 I/O never wide
	wire logic wide = MODE16 && is_mem && !BUS.sbhe_n;
	// All four strobes high marks the end of the host's cycle
	wire logic strobes_idle = BUS.memr_n && BUS.memw_n && BUS.iord_n && BUS.iowr_n;
	// From select and window, not the strobe, so the host sees it early
	// R11 wide acknowledge decode
	wire logic ack16 = MODE16 && BUS.cs && BUS.ref_n && ihb_mem_hit(eff_addr);
	// R13 retrace start edge
	wire logic vr_rise = VRETRACE && !vr_prev_reg;

	// Open-drain lines only ever pull low; the enable decides
	assign BUS.memcs16_n_o = 1'b0;
	assign BUS.iochrdy_o = 1'b0;

	// Address latch follows the bus while the latch enable is high
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			addr_lat_reg <= 19'h0_0000;
		end else if (BUS.sys_reset) begin
			addr_lat_reg <= 19'h0_0000;
		end else if (BUS.bale) begin
			// R08 latch valid address
			addr_lat_reg <= BUS.addr;
		end
	end

	// Wide acknowledge follows the decode each cycle; released otherwise
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			BUS.memcs16_n_oe <= 1'b0;
		end else begin
			// R11 drive acknowledge
			// R15 release when idle
			// R09 system reset clears
			BUS.memcs16_n_oe <= ack16 && !BUS.sys_reset;
		end
	end

	// Retrace interrupt: sticky pending flag, a new edge wins over a clear
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			vr_prev_reg <= 1'b0;
			IRQ_PENDING <= 1'b0;
			BUS.vertical_retrace_irq_o <= 1'b0;
			BUS.vertical_retrace_irq_oe <= 1'b0;
		end else if (BUS.sys_reset) begin
			vr_prev_reg <= 1'b0;
			IRQ_PENDING <= 1'b0;
			BUS.vertical_retrace_irq_o <= 1'b0;
			BUS.vertical_retrace_irq_oe <= 1'b0;
		end else begin
			vr_prev_reg <= VRETRACE;
			// R13 raise at retrace
			IRQ_PENDING <= vr_rise || (IRQ_PENDING && !IRQ_CLR);
			BUS.vertical_retrace_irq_o <= vr_rise || (IRQ_PENDING && !IRQ_CLR);
			// R15 float when disabled
			BUS.vertical_retrace_irq_oe <= IRQ_EN;
		end
	end

	// Transfer sequencer: take the cycle, hold ready low until the core answers,
	// then keep read data on the bus until the host drops its strobe.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= D_IDLE;
			is_read_reg <= 1'b0;
			REQ <= 1'b0;
			REQ_IS_MEM <= 1'b0;
			REQ_WRITE <= 1'b0;
			REQ_WIDE <= 1'b0;
			REQ_ADDR <= 19'h0_0000;
			REQ_WDATA <= 16'h0000;
			BUS.iochrdy_oe <= 1'b0;
			BUS.dev_data_o <= 16'h0000;
			BUS.dev_data_oe <= 1'b0;
			BUS.dir <= 1'b1;
			BUS.upper_byte_buffer_enable_n <= 1'b1;
		end else if (BUS.sys_reset) begin
			// R09 system reset
			state_reg <= D_IDLE;
			is_read_reg <= 1'b0;
			REQ <= 1'b0;
			REQ_IS_MEM <= 1'b0;
			REQ_WRITE <= 1'b0;
			REQ_WIDE <= 1'b0;
			REQ_ADDR <= 19'h0_0000;
			REQ_WDATA <= 16'h0000;
			BUS.iochrdy_oe <= 1'b0;
			BUS.dev_data_o <= 16'h0000;
			BUS.dev_data_oe <= 1'b0;
			BUS.dir <= 1'b1;
			BUS.upper_byte_buffer_enable_n <= 1'b1;
		end else begin
			REQ <= 1'b0;
			unique case (state_reg)
				D_IDLE: begin
					if (start) begin
						REQ <= 1'b1;
						REQ_IS_MEM <= is_mem;
						REQ_WRITE <= !is_read;
						REQ_WIDE <= wide;
						REQ_ADDR <= eff_addr;
						REQ_WDATA <= BUS.data;
						is_read_reg <= is_read;
						// R12 stretch the cycle
						BUS.iochrdy_oe <= 1'b1;
						// R03 point buffer to host
						BUS.dir <= !is_read;
						// R02 open upper lane
						BUS.upper_byte_buffer_enable_n <= !wide;
						state_reg <= D_BUSY;
					end
				end
				D_BUSY: begin
					// The core may take any number of cycles; ready stays low meanwhile
					if (ACK) begin
						// R12 release ready
						BUS.iochrdy_oe <= 1'b0;
						BUS.dev_data_o <= ACK_RDATA;
						BUS.dev_data_oe <= is_read_reg;
						state_reg <= D_DONE;
					end
				end
				D_DONE: begin
					// Data stays until the strobe ends so the host never samples a gap
					if (strobes_idle) begin
						BUS.dev_data_oe <= 1'b0;
						BUS.dir <= 1'b1;
						BUS.upper_byte_buffer_enable_n <= 1'b1;
						state_reg <= D_IDLE;
					end
				end
				default: begin
					state_reg <= D_IDLE;
				end
			endcase
		end
	end

endmodule : ihb_dev

// file: ihb_asserts.sv
// Checker for the host bus between the system end and the controller end.
// Assumes plain copies of the ihb_if signals and one clock domain.
`timescale 1ns/1ps

`include "ihb_cfg.svh"

module ihb_asserts (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic MODE16,
	input wire logic [18:0] addr,
	input wire logic cs,
	input wire logic aen,
	input wire logic sys_reset,
	input wire logic sbhe_n,
	input wire logic iord_n,
	input wire logic iowr_n,
	input wire logic memr_n,
	input wire logic memw_n,
	input wire logic ref_n,
	input wire logic upper_byte_buffer_enable_n,
	input wire logic dir,
	input wire logic memcs16_n_oe,
	input wire logic iochrdy_oe
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	// Address decode for the two windows; live address, host holds it all cycle
	wire mem_hit = cs && ref_n && (addr[18:`IHB_MEM_TAG_LSB] == `IHB_MEM_TAG);
	wire io_hit = !aen && (addr[15:10] == 6'h00) && (addr[9:0] >= `IHB_IO_LO) && (addr[9:0] <= `IHB_IO_HI);

	// A claimed memory cycle starts
	sequence s_mem_go;
		($fell(memr_n) || $fell(memw_n)) && mem_hit;
	endsequence

	// Ready, once pulled low, is let go within a bounded time
	sequence s_hold;
		iochrdy_oe ##[1:40] !iochrdy_oe;
	endsequence

	a_mem_claim: assert property (s_mem_go |=> iochrdy_oe && (dir == memr_n))
		else $error("memory cycle not claimed");
	a_io_claim: assert property (($fell(iord_n) || $fell(iowr_n)) && io_hit |=> iochrdy_oe && (dir == iord_n))
		else $error("io cycle not claimed");
	a_io_narrow: assert property (($fell(iord_n) || $fell(iowr_n)) && io_hit |=> upper_byte_buffer_enable_n)
		else $error("io cycle used upper lane");
	a_dma_ignored: assert property ($fell(iord_n) && aen |=> !iochrdy_oe)
		else $error("dma cycle claimed");
	a_refresh_ignored: assert property ($fell(memr_n) && !ref_n |=> !iochrdy_oe)
		else $error("refresh cycle claimed");
	a_unsel_ignored: assert property ($fell(memr_n) && ref_n && !mem_hit |=> !iochrdy_oe)
		else $error("unselected memory cycle claimed");
	a_upper_lane: assert property (s_mem_go |=> upper_byte_buffer_enable_n == !$past(MODE16 && !sbhe_n))
		else $error("upper lane enable wrong");
	a_ready_hold: assert property ($rose(iochrdy_oe) |-> s_hold)
		else $error("ready stretch wrong");
	a_wide_ack: assert property ($past(RST_N) |-> memcs16_n_oe == $past(MODE16 && mem_hit && !sys_reset))
		else $error("wide acknowledge wrong");
	a_sys_reset: assert property (sys_reset |=> !iochrdy_oe && dir && upper_byte_buffer_enable_n)
		else $error("system reset left bus active");
endmodule : ihb_asserts

// file: testbench.sv
// Testbench: both ends joined by ihb_if, with a small core model on the device.
// Assumes the design files and ihb_cfg.svh are compiled first.
`timescale 1ns/1ps

module testbench
	import ihb_pkg::*;
;
	logic mclk, rst_n, cmd_valid, cmd_wide, reset_req, mode16, irq_en, vretrace, irq_clr, ack, wd;
	ihb_kind_type cmd_kind;
	logic [18:0] cmd_addr;
	logic [15:0] cmd_wdata, ack_rdata, rd, done_rdata, req_wdata;
	logic [18:0] req_addr;
	wire cmd_ready, done, done_wide, irq_seen, req, req_is_mem, req_write, req_wide, irq_pending;
	int fail_count = 0, total_checks = 0, cycles = 0, req_count = 0, ack_dly = 0, got;
	ihb_kind_type skip_kind[6] = '{K_IO_RD, K_IO_RD, K_IO_RD, K_DMA_IO, K_REFRESH, K_MEM_RD};
	logic [18:0] skip_addr[6] = '{19'h0_03AF, 19'h0_03E0, 19'h0_07C0, 19'h0_03C0, 19'h2_0000, 19'h4_0000};

	ihb_if bus();
	ihb_host i_ihb_host (.MCLK(mclk), .RST_N(rst_n), .BUS(bus), .CMD_VALID(cmd_valid), .CMD_KIND(cmd_kind),
		.CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .CMD_WIDE(cmd_wide), .RESET_REQ(reset_req),
		.CMD_READY(cmd_ready), .DONE(done), .DONE_RDATA(done_rdata), .DONE_WIDE(done_wide), .IRQ_SEEN(irq_seen));
	ihb_dev i_ihb_dev (.MCLK(mclk), .RST_N(rst_n), .BUS(bus), .MODE16(mode16), .IRQ_EN(irq_en),
		.VRETRACE(vretrace), .IRQ_CLR(irq_clr), .ACK(ack), .ACK_RDATA(ack_rdata), .REQ(req),
		.REQ_IS_MEM(req_is_mem), .REQ_WRITE(req_write), .REQ_WIDE(req_wide), .REQ_ADDR(req_addr),
		.REQ_WDATA(req_wdata), .IRQ_PENDING(irq_pending));
	ihb_asserts i_ihb_asserts (.MCLK(mclk), .RST_N(rst_n), .MODE16(mode16), .addr(bus.addr), .cs(bus.cs),
		.aen(bus.aen), .sys_reset(bus.sys_reset), .sbhe_n(bus.sbhe_n), .iord_n(bus.iord_n),
		.iowr_n(bus.iowr_n), .memr_n(bus.memr_n), .memw_n(bus.memw_n), .ref_n(bus.ref_n),
		.upper_byte_buffer_enable_n(bus.upper_byte_buffer_enable_n), .dir(bus.dir),
		.memcs16_n_oe(bus.memcs16_n_oe), .iochrdy_oe(bus.iochrdy_oe));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Core model: one ACK per request, after a chosen delay to stretch the cycle
	always @(posedge mclk) begin
		#1;
		if (req === 1'b1) begin
			req_count++;
			repeat (ack_dly) begin
				@(posedge mclk);
				#1;
			end
			ack = 1'b1;
			@(posedge mclk);
			#1 ack = 1'b0;
		end
	end

	// Hang guard, well above the hundred or so cycles the tests need
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			stop_test();
		end
	end

	task automatic chk(input string s, input logic [18:0] e, input logic [18:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	// One host command; got counts device requests, rd and wd hold the answer
	task automatic xfer(input ihb_kind_type k, input logic [18:0] a, input logic [15:0] w, input logic wide);
		int n0;
		n0 = req_count;
		while (cmd_ready !== 1'b1) begin
			@(posedge mclk);
			#1;
		end
		cmd_kind = k;
		cmd_addr = a;
		cmd_wdata = w;
		cmd_wide = wide;
		cmd_valid = 1'b1;
		@(posedge mclk);
		#1 cmd_valid = 1'b0;
		while (done !== 1'b1) begin
			@(posedge mclk);
			#1;
		end
		rd = done_rdata;
		wd = done_wide;
		got = req_count - n0;
	endtask : xfer

	task automatic stop_test;
		$display("Checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	initial begin
		{rst_n, cmd_valid, cmd_wide, reset_req, irq_en, vretrace, irq_clr, ack} = '0;
		cmd_kind = K_IO_RD;
		cmd_addr = '0;
		cmd_wdata = '0;
		mode16 = 1'b1;
		ack_rdata = 16'h5A3C;
		repeat (2) @(posedge mclk);
		#1 rst_n = 1'b1;
		// I/O at both window edges stays one byte even when asked wide
		xfer(K_IO_WR, 19'h0_03B0, 16'h1234, 1'b1);
		chk("io wr kind", 19'h0_000A, {got[15:0], req_is_mem, req_write, req_wide});
		chk("io wr data", 19'h0_0034, req_wdata[7:0]);
		xfer(K_IO_RD, 19'h0_03DF, 16'h0000, 1'b1);
		chk("io rd kind", 19'h0_0008, {got[15:0], req_is_mem, req_write, req_wide});
		chk("io rd data", 19'h0_003C, rd[7:0]);
		$display("io window test done");
		// Cycles left alone: outside window, DMA, refresh, out of memory range
		for (int i = 0; i < 6; i++) begin
			xfer(skip_kind[i], skip_addr[i], 16'h0000, 1'b0);
			chk("skip req", 0, got);
			chk("skip data", 19'h0_FFFF, rd);
			chk("skip wide", 0, wd);
		end
		$display("ignore test done");
		// Wide memory write, then a stretched wide read
		xfer(K_MEM_WR, 19'h2_0010, 16'hBEEF, 1'b1);
		chk("mw kind", 19'h0_000F, {got[15:0], req_is_mem, req_write, req_wide});
		chk("mw data", 19'h0_BEEF, req_wdata);
		chk("mw addr", 19'h2_0010, req_addr);
		chk("mw ack16", 1, wd);
		ack_dly = 6;
		ack_rdata = 16'hC0DE;
		xfer(K_MEM_RD, 19'h3_FFFE, 16'h0000, 1'b1);
		chk("mr kind", 19'h0_000D, {got[15:0], req_is_mem, req_write, req_wide});
		chk("mr data", 19'h0_C0DE, rd);
		// 8-bit mode: byte-high enable no longer counts
		mode16 = 1'b0;
		ack_dly = 0;
		xfer(K_MEM_RD, 19'h2_0001, 16'h0000, 1'b1);
		chk("m8 kind", 19'h0_000C, {got[15:0], req_is_mem, req_write, req_wide});
		chk("m8 ack16", 0, wd);
		chk("m8 data", 19'h0_00DE, rd[7:0]);
		$display("memory test done");
		// Retrace interrupt: pending while line released, then driven, then cleared
		vretrace = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		chk("irq pend", 1, irq_pending);
		chk("irq released", 0, {irq_seen, bus.vertical_retrace_irq_oe});
		irq_en = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		chk("irq line", 1, irq_seen);
		irq_clr = 1'b1;
		@(posedge mclk);
		#1 irq_clr = 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		chk("irq clear", 0, {irq_pending, irq_seen});
		// Fresh retrace edge in the same cycle as a clear: the edge wins
		vretrace = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		vretrace = 1'b1;
		irq_clr = 1'b1;
		@(posedge mclk);
		#1 irq_clr = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		chk("irq edge wins", 19'h0_0003, {irq_pending, irq_seen});
		$display("interrupt test done");
		// System reset mid-run clears device state; bus works again after
		reset_req = 1'b1;
		repeat (3) @(posedge mclk);
		#1 reset_req = 1'b0;
		chk("rst state", 19'h0_0003, {irq_pending, bus.memcs16_n_oe, bus.dir, bus.upper_byte_buffer_enable_n});
		xfer(K_IO_RD, 19'h0_03C4, 16'h0000, 1'b0);
		chk("rst after", 1, got);
		$display("system reset test done");
		stop_test();
	end
endmodule : testbench
